// >>> common/tx_slot_pkg.sv
// Purpose: Shared constants, enums and structs for the transmit slot configuration block
// Assumes: Processor addresses count 16-bit units; one 32-bit word spans two addresses
// Notes: Bit positions refer to the 32-bit memory words
package tx_slot_pkg;
  // Memory regions, each 8 ports x 32 slots
  localparam logic [17:0] CFG_BASE = 18'h00400;
  localparam logic [17:0] EXT_BASE = 18'h00600;
  localparam logic [17:0] COND_BASE = 18'h00800;
  // Block registers
  localparam logic [17:0] PAT_LOW_ADDR = 18'h00010;
  localparam logic [17:0] PAT_HIGH_ADDR = 18'h00012;
  localparam logic [17:0] PORT_MODE_ADDR = 18'h00014;
  localparam logic [17:0] ATM_CNT_EN_ADDR = 18'h00016;
  localparam logic [17:0] AAL_CNT_EN_ADDR = 18'h00018;
  localparam logic [17:0] STATUS_ADDR = 18'h0001a;
  // External RAM map
  localparam logic [17:0] RG_CNT_BASE = 18'h20000;
  localparam logic [17:0] RG_THR_BASE = 18'h22000;
  localparam logic [17:0] RG_IRQ_BASE = 18'h24000;
  localparam logic [17:0] RG_TMR_BASE = 18'h26000;
  localparam logic [17:0] RG_INS_BASE = 18'h26020;
  localparam logic [17:0] RG_EXT_BASE = 18'h26040;
  localparam logic [17:0] RG_RXB_BASE = 18'h28000;
  localparam logic [17:0] RG_TXB_BASE = 18'h30000;
  localparam int EXT_WORDS = 65536;
  localparam int COUNTERS_PER_CHAN = 16;
  // Base word fields
  localparam int REF_BIT = 0;
  localparam int CONT_BIT = 1;
  localparam int MODE_LO = 2;
  localparam int SDT_BIT = 4;
  localparam int ANCHOR_LO = 2;
  localparam int IDLE_SEL_LO = 7;
  localparam int INDEX_LO = 8;
  localparam int RAW_BIT = 15;
  localparam int SUCC_LO = 27;
  localparam logic [4:0] FIRST_CONT_INDEX = 5'h02;
  localparam logic [4:0] LAST_CONT_INDEX = 5'h1e;
  // Extended word fields
  localparam int UF_BIT = 0;
  localparam int OF_BIT = 1;
  localparam int LSIZE_LO = 2;
  localparam int STARV_CNT_LO = 16;
  localparam int STARV_SEL_LO = 28;
  localparam logic [10:0] STARV_UNLIMITED = 11'h7ff;
  // Conditioning word fields
  localparam int NIB_LO = 0;
  localparam int COND_EN_BIT = 4;

  typedef enum logic [1:0] {SLOT_IDLE, SLOT_REF, SLOT_CONT} slot_kind_t;
  typedef enum logic [1:0] {CH_INACTIVE, CH_ACTIVE, CH_STANDBY} chan_state_t;
  typedef enum logic [3:0] {RG_COUNTERS, RG_THRESH, RG_IRQ_QUEUE, RG_TIMERS, RG_INSERT, RG_EXTRACT,
                            RG_RX_BUF, RG_TX_BUF, RG_NONE} ram_region_t;

  typedef struct packed {
    slot_kind_t kind;
    chan_state_t state;
    logic sdt_on;
    logic raw_cell;
    logic [4:0] chain_successor;
    logic [4:0] anchor_number;
    logic index_valid;
    logic [4:0] slot_index;
    logic [7:0] idle_byte;
    logic ext_valid;
    logic [7:0] starv_byte;
    logic [11:0] starv_octets;
    logic starv_unlimited;
    logic [13:0] buf_lsize;
    logic overflow_self_restart;
    logic underflow_self_restart;
    logic cond_valid;
    logic cond_substitute;
    logic [3:0] cond_nibble;
  } slot_view_t;
endpackage

// >>> hw/ext_ram_map.sv
// Purpose: Maps processor addresses onto the external RAM and names the region
// Assumes: External RAM words are 32 bits, two processor addresses each
// Notes: Combinational
`timescale 1ns/1ps
`default_nettype none
module ext_ram_map (
  input wire logic [17:0] processor_address_in, // Processor address
  output logic hit_out, // Address lies in external RAM
  output logic [15:0] external_memory_address_out, // RAM word address
  output tx_slot_pkg::ram_region_t region_out // Region name
);
  // Upper half of the processor space is external RAM
  assign hit_out = processor_address_in[17];
  assign external_memory_address_out = processor_address_in[16:1];

  // Region boundaries, highest first
  always_comb begin
    if (!processor_address_in[17]) begin
      region_out = tx_slot_pkg::RG_NONE;
    end else if (processor_address_in >= tx_slot_pkg::RG_TXB_BASE) begin
      region_out = tx_slot_pkg::RG_TX_BUF;
    end else if (processor_address_in >= tx_slot_pkg::RG_RXB_BASE) begin
      region_out = tx_slot_pkg::RG_RX_BUF;
    end else if (processor_address_in >= tx_slot_pkg::RG_EXT_BASE) begin
      region_out = tx_slot_pkg::RG_EXTRACT;
    end else if (processor_address_in >= tx_slot_pkg::RG_INS_BASE) begin
      region_out = tx_slot_pkg::RG_INSERT;
    end else if (processor_address_in >= tx_slot_pkg::RG_TMR_BASE) begin
      region_out = tx_slot_pkg::RG_TIMERS;
    end else if (processor_address_in >= tx_slot_pkg::RG_IRQ_BASE) begin
      region_out = tx_slot_pkg::RG_IRQ_QUEUE;
    end else if (processor_address_in >= tx_slot_pkg::RG_THR_BASE) begin
      region_out = tx_slot_pkg::RG_THRESH;
    end else begin
      region_out = tx_slot_pkg::RG_COUNTERS;
    end
  end
endmodule // ext_ram_map
`default_nettype wire

// >>> hw/slot_decoder.sv
// Purpose: Decodes the three per-slot words into a slot view
// Assumes: Port modes come from the block's port mode register
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module slot_decoder (
  input wire logic [31:0] cfg_in, // Base word
  input wire logic [31:0] ext_in, // Extended word
  input wire logic [31:0] cond_in, // Conditioning word
  input wire logic ces_in, // Port in unstructured emulation
  input wire logic cas_in, // Port carries CAS
  input wire logic [15:0] pattern_pair_low_in, // Patterns 1:0
  input wire logic [15:0] pattern_pair_high_in, // Patterns 3:2
  output tx_slot_pkg::slot_view_t view_out // Decoded view
);
  // Pattern selector shared by idle and starvation
  function automatic logic [7:0] pick_pattern(input logic [1:0] sel, input logic [15:0] lo,
                                              input logic [15:0] hi);
    logic [7:0] b;
    b = 8'h00;
    unique case (sel)
      2'b00: b = lo[7:0];
      2'b01: b = lo[15:8];
      2'b10: b = hi[7:0];
      2'b11: b = hi[15:8];
    endcase
    return b;
  endfunction

  wire logic is_ref = cfg_in[tx_slot_pkg::REF_BIT];
  wire logic is_cont = ~is_ref & cfg_in[tx_slot_pkg::CONT_BIT];
  wire logic raw = is_ref & cfg_in[tx_slot_pkg::RAW_BIT];
  wire logic [1:0] mode = cfg_in[tx_slot_pkg::MODE_LO +: 2];
  wire logic aal_ref = is_ref;
  wire logic [10:0] starv = ext_in[tx_slot_pkg::STARV_CNT_LO +: 11];
  wire logic [4:0] idx = cfg_in[tx_slot_pkg::INDEX_LO +: 5];

  // Field extraction
  always_comb begin
    view_out = '0;
    view_out.kind = is_ref ? tx_slot_pkg::SLOT_REF : (is_cont ? tx_slot_pkg::SLOT_CONT : tx_slot_pkg::SLOT_IDLE);
    view_out.state = ~is_ref ? tx_slot_pkg::CH_INACTIVE : (mode == 2'b00) ? tx_slot_pkg::CH_INACTIVE :
                     (mode == 2'b10) ? tx_slot_pkg::CH_STANDBY : tx_slot_pkg::CH_ACTIVE;
    view_out.raw_cell = raw;
    view_out.sdt_on = is_ref & cfg_in[tx_slot_pkg::SDT_BIT] & ~ces_in & ~raw;
    view_out.chain_successor = cfg_in[tx_slot_pkg::SUCC_LO +: 5];
    view_out.anchor_number = is_cont ? cfg_in[tx_slot_pkg::ANCHOR_LO +: 5] : 5'h00;
    view_out.index_valid = is_cont & cas_in & (idx >= tx_slot_pkg::FIRST_CONT_INDEX)
                           & (idx <= tx_slot_pkg::LAST_CONT_INDEX);
    view_out.slot_index = view_out.index_valid ? idx : 5'h00;
    view_out.idle_byte = (~is_ref & ~is_cont) ? pick_pattern(cfg_in[tx_slot_pkg::IDLE_SEL_LO +: 2],
                         pattern_pair_low_in, pattern_pair_high_in) : 8'h00;
    view_out.ext_valid = aal_ref;
    if (aal_ref) begin
      view_out.starv_byte = pick_pattern(ext_in[tx_slot_pkg::STARV_SEL_LO +: 2], pattern_pair_low_in,
                                         pattern_pair_high_in);
      view_out.starv_unlimited = (starv == tx_slot_pkg::STARV_UNLIMITED);
      view_out.starv_octets = view_out.starv_unlimited ? 12'h000 : ({1'b0, starv} + 12'h001);
      view_out.buf_lsize = ext_in[tx_slot_pkg::LSIZE_LO +: 14];
      view_out.overflow_self_restart = ext_in[tx_slot_pkg::OF_BIT] & ~raw;
      view_out.underflow_self_restart = ext_in[tx_slot_pkg::UF_BIT] & ~raw;
    end
    view_out.cond_valid = aal_ref & cas_in;
    view_out.cond_substitute = view_out.cond_valid & cond_in[tx_slot_pkg::COND_EN_BIT];
    view_out.cond_nibble = view_out.cond_valid ? cond_in[tx_slot_pkg::NIB_LO +: 4] : 4'h0;
  end
endmodule // slot_decoder
`default_nettype wire

// >>> hw/tx_slot_config_memory.sv
// Purpose: Transmit slot configuration memories, external RAM access and counter gating
// Assumes: One clock; processor addresses count 16-bit units; external RAM answers in one cycle
// Notes: Configuration memories have no reset and must be filled by software
// Functional notes
// - Structured transfer bit enables it; ignored for unstructured ports or raw cells
// - Channel state 00 inactive, 01 active, 10 standby, 11 active
// - Word with bit 0 set is a channel reference slot
// - Continuation word: successor 31:27, index 12:8, anchor 6:2, flag bit 1
// - Slot index 2 to 30 marks continuation order; ignored without CAS
// - Bit 1 set means continuation; both flags clear means idle slot
// - Idle selector bits 8:7 picks one of four byte patterns
// - Starvation selector bits 29:28 picks pattern with the same code
// - Extended word only matters for reference slots
// - Starvation count sends count plus one octets; 2047 means unlimited
// - Bits 15:2 of extended word give logical buffer size in octets
// - Overflow bit selects self restart on overflow; ignored for raw cells
// - Underflow bit selects self restart on underflow; ignored for raw cells
// - Conditioning word only matters for reference slots of CAS ports
// - On fault, freeze CAS nibble or substitute programmed nibble
// - Memories are 8 ports by 32 slots at 00400, 00600, 00800
// - External RAM is 64K words of 32 bits plus parity
// - External RAM regions mapped at fixed processor addresses
// - Counter area holds 16 counters per channel per port
// - Counters increment only for active or standby channels with enable set
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tx_slot_config_memory (
  input wire logic clk_in, // 50 MHz clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic [17:0] processor_address_in, // Register address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  input wire logic [2:0] sel_port_in, // Slot lookup port
  input wire logic [4:0] sel_slot_in, // Slot lookup slot
  output tx_slot_pkg::slot_view_t view_out, // Decoded slot, one cycle later
  input wire logic overflow_in, // Buffer overflow of looked-up channel
  input wire logic underflow_in, // Buffer underflow of looked-up channel
  output logic self_restart_out, // Device restarts buffer itself
  output logic cpu_restart_out, // Restart left to software
  input wire logic cas_fault_in, // Underrun or pointer mismatch
  input wire logic [3:0] cas_live_nibble_in, // Received CAS nibble
  output logic [3:0] cas_nibble_out, // Downstream CAS nibble
  input wire logic cnt_event_in, // Counter event pulse
  input wire logic cnt_aal_in, // Event belongs to an AAL port
  input wire logic [2:0] cnt_port_in, // Event port
  input wire logic [4:0] cnt_chan_in, // Event channel
  input wire logic [3:0] cnt_sel_in, // Event counter number
  output logic cnt_inc_out, // Increment pulse
  output logic [15:0] cnt_addr_out, // External word to increment
  output logic ext_wr_out, // External RAM write
  output logic ext_rd_out, // External RAM read
  output logic [15:0] external_memory_address_out, // External RAM address
  output logic [31:0] ext_wdata_out, // External RAM write data
  output logic ext_wpar_out, // External RAM write parity
  input wire logic [31:0] ext_rdata_in, // External RAM read data
  input wire logic ext_rpar_in, // External RAM read parity
  output tx_slot_pkg::ram_region_t ext_region_out, // Region of the access
  output logic par_err_out // Parity error pulse
);
  localparam int SLOTS = 256;

  // Configuration memories, no reset by design
  logic [31:0] cfg_mem [SLOTS];
  logic [31:0] ext_mem [SLOTS];
  logic [31:0] cond_mem [SLOTS];

  logic [15:0] pattern_pair_low_ff, pattern_pair_high_ff;
  logic [15:0] port_mode_ff, atm_cnt_en_ff, aal_cnt_en_ff;
  logic [15:0] gated_cnt_ff, par_cnt_ff;
  logic [31:0] rdata_ff;
  logic ext_rd_pend_ff;
  tx_slot_pkg::slot_view_t view_ff;
  logic self_restart_ff, cpu_restart_ff;
  logic [3:0] cas_ff;
  logic cnt_inc_ff;
  logic [15:0] cnt_addr_ff;
  logic ext_wr_ff, ext_rd_ff, ext_wpar_ff, par_err_ff;
  logic [15:0] ext_addr_ff;
  logic [31:0] ext_wdata_ff;
  tx_slot_pkg::ram_region_t region_ff;

  // Region decode: addresses in 16-bit units, index from bits 8:1
  function automatic logic in_region(input logic [17:0] a, input logic [17:0] base);
    return a[17:9] == base[17:9];
  endfunction

  wire logic [7:0] bus_index = processor_address_in[8:1];
  wire logic hit_cfg = in_region(processor_address_in, tx_slot_pkg::CFG_BASE);
  wire logic hit_ext = in_region(processor_address_in, tx_slot_pkg::EXT_BASE);
  wire logic hit_cond = in_region(processor_address_in, tx_slot_pkg::COND_BASE);
  wire logic ram_hit;
  wire logic [15:0] ram_addr;
  tx_slot_pkg::ram_region_t ram_region;

  ext_ram_map u_map (
    .processor_address_in(processor_address_in),
    .hit_out(ram_hit),
    .external_memory_address_out(ram_addr),
    .region_out(ram_region)
  );

  // Memory writes
  always_ff @(posedge clk_in) begin
    if (wr_in && hit_cfg) begin
      cfg_mem[bus_index] <= wdata_in;
    end
    if (wr_in && hit_ext) begin
      ext_mem[bus_index] <= wdata_in;
    end
    if (wr_in && hit_cond) begin
      cond_mem[bus_index] <= wdata_in;
    end
  end

  // Register writes
  wire logic wr_pat_lo = wr_in && processor_address_in == tx_slot_pkg::PAT_LOW_ADDR;
  wire logic wr_pat_hi = wr_in && processor_address_in == tx_slot_pkg::PAT_HIGH_ADDR;
  wire logic wr_mode = wr_in && processor_address_in == tx_slot_pkg::PORT_MODE_ADDR;
  wire logic wr_atm_en = wr_in && processor_address_in == tx_slot_pkg::ATM_CNT_EN_ADDR;
  wire logic wr_aal_en = wr_in && processor_address_in == tx_slot_pkg::AAL_CNT_EN_ADDR;
  wire logic wr_status = wr_in && processor_address_in == tx_slot_pkg::STATUS_ADDR;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pattern_pair_low_ff <= 16'h0000;
      pattern_pair_high_ff <= 16'h0000;
      port_mode_ff <= 16'h0000;
      atm_cnt_en_ff <= 16'h0000;
      aal_cnt_en_ff <= 16'h0000;
    end else begin
      if (wr_pat_lo) pattern_pair_low_ff <= wdata_in[15:0];
      if (wr_pat_hi) pattern_pair_high_ff <= wdata_in[15:0];
      if (wr_mode) port_mode_ff <= wdata_in[15:0];
      if (wr_atm_en) atm_cnt_en_ff <= wdata_in[15:0];
      if (wr_aal_en) aal_cnt_en_ff <= wdata_in[15:0];
    end
  end

  // Read data select
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_cfg) nxt_rdata = cfg_mem[bus_index];
    else if (hit_ext) nxt_rdata = ext_mem[bus_index];
    else if (hit_cond) nxt_rdata = cond_mem[bus_index];
    else if (processor_address_in == tx_slot_pkg::PAT_LOW_ADDR) nxt_rdata = {16'h0000, pattern_pair_low_ff};
    else if (processor_address_in == tx_slot_pkg::PAT_HIGH_ADDR) nxt_rdata = {16'h0000, pattern_pair_high_ff};
    else if (processor_address_in == tx_slot_pkg::PORT_MODE_ADDR) nxt_rdata = {16'h0000, port_mode_ff};
    else if (processor_address_in == tx_slot_pkg::ATM_CNT_EN_ADDR) nxt_rdata = {16'h0000, atm_cnt_en_ff};
    else if (processor_address_in == tx_slot_pkg::AAL_CNT_EN_ADDR) nxt_rdata = {16'h0000, aal_cnt_en_ff};
    else if (processor_address_in == tx_slot_pkg::STATUS_ADDR) nxt_rdata = {par_cnt_ff, gated_cnt_ff};
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_ff <= 32'h0000_0000;
      ext_rd_pend_ff <= 1'b0;
    end else begin
      rdata_ff <= rd_in ? nxt_rdata : 32'h0000_0000;
      ext_rd_pend_ff <= rd_in & ram_hit;
    end
  end
  // External RAM data arrives from its own output register in the answer cycle
  assign rdata_out = ext_rd_pend_ff ? ext_rdata_in : rdata_ff;

  // External RAM access and parity
  wire logic nxt_par_err = ext_rd_pend_ff & (ext_rpar_in != ^ext_rdata_in);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ext_wr_ff <= 1'b0;
      ext_rd_ff <= 1'b0;
      ext_addr_ff <= 16'h0000;
      ext_wdata_ff <= 32'h0000_0000;
      ext_wpar_ff <= 1'b0;
      region_ff <= tx_slot_pkg::RG_NONE;
      par_err_ff <= 1'b0;
    end else begin
      ext_wr_ff <= wr_in & ram_hit;
      ext_rd_ff <= 1'b0;
      par_err_ff <= nxt_par_err;
      if (ram_hit && (wr_in || rd_in)) begin
        ext_addr_ff <= ram_addr;
        ext_wdata_ff <= wdata_in;
        ext_wpar_ff <= ^wdata_in;
        region_ff <= ram_region;
      end
    end
  end
  // Read goes out in the strobe cycle so data returns in the answer cycle
  assign ext_rd_out = rd_in & ram_hit;
  assign ext_wr_out = ext_wr_ff;
  assign external_memory_address_out = ext_rd_out ? ram_addr : ext_addr_ff;
  assign ext_wdata_out = ext_wdata_ff;
  assign ext_wpar_out = ext_wpar_ff;
  assign ext_region_out = region_ff;
  assign par_err_out = par_err_ff;

  // Slot lookup for the transmit engine
  wire logic [7:0] sel_index = {sel_port_in, sel_slot_in};
  tx_slot_pkg::slot_view_t sel_view;
  slot_decoder u_dec (
    .cfg_in(cfg_mem[sel_index]),
    .ext_in(ext_mem[sel_index]),
    .cond_in(cond_mem[sel_index]),
    .ces_in(port_mode_ff[sel_port_in]),
    .cas_in(port_mode_ff[{1'b1, sel_port_in}]),
    .pattern_pair_low_in(pattern_pair_low_ff),
    .pattern_pair_high_in(pattern_pair_high_ff),
    .view_out(sel_view)
  );

  // Buffer restart and CAS conditioning
  wire logic any_fault = overflow_in | underflow_in;
  wire logic self_ok = (overflow_in & sel_view.overflow_self_restart)
                       | (underflow_in & sel_view.underflow_self_restart);
  logic [3:0] nxt_cas;
  always_comb begin
    nxt_cas = cas_live_nibble_in;
    if (cas_fault_in && sel_view.cond_valid) begin
      nxt_cas = sel_view.cond_substitute ? sel_view.cond_nibble : cas_ff;
    end
  end
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      view_ff <= '0;
      self_restart_ff <= 1'b0;
      cpu_restart_ff <= 1'b0;
      cas_ff <= 4'h0;
    end else begin
      view_ff <= sel_view;
      self_restart_ff <= sel_view.ext_valid & self_ok;
      cpu_restart_ff <= sel_view.ext_valid & any_fault & ~self_ok & ~sel_view.raw_cell;
      cas_ff <= nxt_cas;
    end
  end
  assign view_out = view_ff;
  assign self_restart_out = self_restart_ff;
  assign cpu_restart_out = cpu_restart_ff;
  assign cas_nibble_out = cas_ff;

  // Statistics counter gating
  wire logic [31:0] cnt_word = cfg_mem[{cnt_port_in, cnt_chan_in}];
  wire logic [1:0] cnt_mode = cnt_word[tx_slot_pkg::MODE_LO +: 2];
  wire logic chan_live = cnt_word[tx_slot_pkg::REF_BIT] & (cnt_mode != 2'b00);
  wire logic [15:0] en_mask = cnt_aal_in ? aal_cnt_en_ff : atm_cnt_en_ff;
  wire logic cnt_ok = cnt_event_in & chan_live & en_mask[cnt_sel_in];
  wire logic [15:0] nxt_cnt_addr = {4'h0, cnt_port_in, cnt_chan_in, cnt_sel_in};
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_inc_ff <= 1'b0;
      cnt_addr_ff <= 16'h0000;
      gated_cnt_ff <= 16'h0000;
      par_cnt_ff <= 16'h0000;
    end else begin
      cnt_inc_ff <= cnt_ok;
      if (cnt_ok) cnt_addr_ff <= nxt_cnt_addr;
      // A new gated event or parity error wins over a software clear of its count
      if (cnt_event_in && !cnt_ok) gated_cnt_ff <= gated_cnt_ff + 16'h0001;
      else if (wr_status) gated_cnt_ff <= 16'h0000;
      if (nxt_par_err) par_cnt_ff <= par_cnt_ff + 16'h0001;
      else if (wr_status) par_cnt_ff <= 16'h0000;
    end
  end
  assign cnt_inc_out = cnt_inc_ff;
  assign cnt_addr_out = cnt_addr_ff;
endmodule // tx_slot_config_memory
`default_nettype wire

// >>> testbench/tb_tx_slot_config_memory.sv
// Purpose: Self-checking bench for the slot configuration block
// Assumes: 50 MHz clock, reset held three cycles
// Notes: Bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module tb_tx_slot_config_memory;
  logic clk_in = 1'b0, srst_in = 1'b1, wr = 1'b0, rd = 1'b0, ov = 1'b0, un = 1'b0, cf = 1'b0, ce = 1'b0;
  logic caal = 1'b0, pb = 1'b0, sres, cres, inc, pe;
  logic [17:0] adr = 18'h0;
  logic [31:0] wd = 32'h0, rdata, rx = 32'h5a5a_1234;
  logic [15:0] caddr;
  logic [4:0] ss = 5'h0, cc = 5'h0;
  logic [3:0] cs = 4'h0, ln = 4'h5, nib;
  logic [1:0] st [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  logic [10:0] sc [3] = '{11'h000, 11'h7fe, 11'h7ff};
  logic [11:0] so [3] = '{12'h001, 12'h7ff, 12'h000};
  logic [9:0] ev [3] = '{10'h202, 10'h002, 10'h222};
  tx_slot_pkg::slot_view_t v;
  tx_slot_pkg::ram_region_t reg_o;
  int fails = 0, tests_run = 0;
  always #10 clk_in = ~clk_in;
  tx_slot_config_memory dut (.clk_in(clk_in), .srst_in(srst_in), .processor_address_in(adr), .wdata_in(wd),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .sel_port_in(3'h0), .sel_slot_in(ss), .view_out(v),
    .overflow_in(ov), .underflow_in(un), .self_restart_out(sres), .cpu_restart_out(cres), .cas_fault_in(cf),
    .cas_live_nibble_in(ln), .cas_nibble_out(nib), .cnt_event_in(ce), .cnt_aal_in(caal), .cnt_port_in(3'h0),
    .cnt_chan_in(cc), .cnt_sel_in(cs), .cnt_inc_out(inc), .cnt_addr_out(caddr), .ext_wr_out(), .ext_rd_out(),
    .external_memory_address_out(), .ext_wdata_out(), .ext_wpar_out(), .ext_rdata_in(rx), .ext_rpar_in(^rx ^ pb),
    .ext_region_out(reg_o), .par_err_out(pe));
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus cycle; a read compares the data of the following cycle
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_in);
    if (!w) cmp(rdata, d);
  endtask
  task automatic look(input logic [4:0] s);
    @(posedge clk_in);
    ss <= s;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // Two-cycle fault or event pulse; live nibble steps each time
  task automatic pulse(input logic [3:0] p, input logic [9:0] f);
    @(posedge clk_in);
    {ov, un, cf, ce} <= p;
    {caal, cc, cs} <= f;
    ln <= ln + 4'h1;
    repeat (2) @(posedge clk_in);
    {ov, un, cf, ce} <= 4'h0;
    @(negedge clk_in);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_in);
    srst_in <= 1'b0;
    acc(1'b0, tx_slot_pkg::STATUS_ADDR, 32'h0);
    acc(1'b1, tx_slot_pkg::PAT_LOW_ADDR, 32'h2211);
    acc(1'b1, tx_slot_pkg::PAT_HIGH_ADDR, 32'h4433);
    acc(1'b1, tx_slot_pkg::PORT_MODE_ADDR, 32'h101);
    for (int m = 0; m < 4; m++) begin
      acc(1'b1, tx_slot_pkg::CFG_BASE, 32'h0000_0011 | m << 2);
      look(5'h00);
      cmp({v.state, v.sdt_on}, {st[m], 1'b0});
      if (m == 0) repeat (12500) @(posedge clk_in);
    end
    acc(1'b1, tx_slot_pkg::PORT_MODE_ADDR, 32'h100);
    acc(1'b0, tx_slot_pkg::CFG_BASE, 32'h0000_001d);
    look(5'h00);
    cmp({v.kind, v.sdt_on, v.chain_successor}, {tx_slot_pkg::SLOT_REF, 1'b1, 5'h00});
    acc(1'b1, 18'h00402, 32'h1800_0206);
    look(5'h01);
    cmp({v.kind, v.index_valid, v.slot_index, v.chain_successor, v.anchor_number},
      {tx_slot_pkg::SLOT_CONT, 1'b1, 5'h02, 5'h03, 5'h01});
    acc(1'b1, 18'h00404, 32'h0000_0180);
    look(5'h02);
    cmp({v.kind, v.idle_byte, v.ext_valid, v.cond_valid}, {tx_slot_pkg::SLOT_IDLE, 8'h44, 2'b00});
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, tx_slot_pkg::EXT_BASE, 32'h1000_48d2 | sc[i] << 16);
      look(5'h00);
      cmp({v.ext_valid, v.starv_byte, v.starv_unlimited, v.starv_octets, v.buf_lsize, v.overflow_self_restart,
        v.underflow_self_restart}, {1'b1, 8'h22, i == 2, so[i], 14'h1234, 2'b10});
    end
    pulse(4'h8, 10'h0);
    cmp({sres, cres}, 2'b10);
    pulse(4'h4, 10'h0);
    cmp({sres, cres}, 2'b01);
    acc(1'b1, tx_slot_pkg::COND_BASE, 32'h0000_001a);
    pulse(4'h2, 10'h0);
    cmp(nib, 4'ha);
    acc(1'b1, tx_slot_pkg::COND_BASE, 32'h0000_000b);
    pulse(4'h2, 10'h0);
    cmp(nib, ln - 4'h1);
    acc(1'b1, tx_slot_pkg::AAL_CNT_EN_ADDR, 32'h0004);
    for (int i = 0; i < 3; i++) begin
      pulse(4'h1, ev[i]);
      cmp({inc, caddr}, (i == 0) ? 17'h1_0002 : 17'h0_0002);
    end
    acc(1'b0, tx_slot_pkg::STATUS_ADDR, 32'h0000_0004);
    acc(1'b1, 18'h20004, 32'h0000_00ff);
    acc(1'b0, 18'h20000, rx);
    cmp(reg_o, tx_slot_pkg::RG_COUNTERS);
    acc(1'b0, 18'h3fffe, rx);
    cmp(reg_o, tx_slot_pkg::RG_TX_BUF);
    @(posedge clk_in) pb <= 1'b1;
    acc(1'b0, 18'h20000, rx);
    @(posedge clk_in) pb <= 1'b0;
    @(negedge clk_in) cmp(pe, 1'b1);
    acc(1'b0, tx_slot_pkg::STATUS_ADDR, 32'h0001_0004);
    acc(1'b0, 18'h01000, 32'h0);
    print_verdict;
  end
endmodule // tb_tx_slot_config_memory
`default_nettype wire

// >>> testbench/tx_slot_asserts.sv
// Purpose: Port-level checks for the slot configuration block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module tx_slot_asserts (
  input wire logic clk_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic [17:0] processor_address_in, // Address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [31:0] rdata_out, // Read data
  input wire tx_slot_pkg::slot_view_t view_out, // Slot view
  input wire logic overflow_in, // Overflow
  input wire logic underflow_in, // Underflow
  input wire logic self_restart_out, // Self restart
  input wire logic cpu_restart_out, // Software restart
  input wire logic cnt_event_in, // Counter event
  input wire logic [2:0] cnt_port_in, // Event port
  input wire logic [4:0] cnt_chan_in, // Event channel
  input wire logic [3:0] cnt_sel_in, // Event counter
  input wire logic cnt_inc_out, // Increment
  input wire logic [15:0] cnt_addr_out, // Counter word
  input wire logic ext_wr_out, // RAM write
  input wire logic ext_rd_out, // RAM read
  input wire logic [15:0] external_memory_address_out, // RAM address
  input wire logic [31:0] ext_wdata_out, // RAM data
  input wire logic ext_wpar_out // RAM parity
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Bus, external RAM, counter and view relations
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
  chk_ext_rd_strobe: assert property (ext_rd_out == (rd_in && processor_address_in[17]))
    else $error("external read strobe wrong");
  chk_ext_rd_addr: assert property (ext_rd_out |-> external_memory_address_out == processor_address_in[16:1])
    else $error("external read address wrong");
  chk_ext_wr_data: assert property (wr_in && processor_address_in[17] |=> ext_wr_out &&
    ext_wdata_out == $past(wdata_in) && ext_wpar_out == ^ext_wdata_out) else $error("external write wrong");
  chk_ext_wr_cause: assert property (ext_wr_out |-> $past(wr_in && processor_address_in[17]))
    else $error("external write without request");
  chk_cnt_word: assert property (cnt_inc_out |-> $past(cnt_event_in) &&
    cnt_addr_out == {4'h0, $past(cnt_port_in), $past(cnt_chan_in), $past(cnt_sel_in)}) else $error("counter word wrong");
  chk_restart_cause: assert property (self_restart_out || cpu_restart_out |->
    !(self_restart_out && cpu_restart_out) && $past(overflow_in || underflow_in)) else $error("restart wrong");
  chk_starv_unlim: assert property (view_out.starv_unlimited |-> view_out.starv_octets == 12'h000)
    else $error("unlimited starvation with count");
  chk_index_range: assert property (view_out.index_valid |-> view_out.slot_index inside {[5'h02:5'h1e]})
    else $error("slot index out of range");
endmodule // tx_slot_asserts
bind tx_slot_config_memory tx_slot_asserts u_chk (.clk_in, .srst_in, .processor_address_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .view_out, .overflow_in, .underflow_in, .self_restart_out, .cpu_restart_out, .cnt_event_in,
  .cnt_port_in, .cnt_chan_in, .cnt_sel_in, .cnt_inc_out, .cnt_addr_out, .ext_wr_out, .ext_rd_out,
  .external_memory_address_out, .ext_wdata_out, .ext_wpar_out);
`default_nettype wire
